// File: design/udc_cascade.sv
// Terminal count and gated ripple outputs for cascading stages
module udc_cascade
    import udc_pkg::*;
(
    // Count clock and state
    input wire logic clk,
    input wire logic [CNT_W-1:0] count_val,
    input wire logic down_sel,
    input wire logic count_enable,
    // Cascade outputs
    output logic term_count,
    output logic ripple_pulse_n
);

    logic at_term;

    // Follows the count, so it lasts about one whole clock period
    assign at_term = udc_at_terminal(count_val, down_sel);
    assign term_count = at_term;

    // Low phase only; an inhibited stage passes no carry or borrow
    assign ripple_pulse_n = ~(at_term & count_enable & ~clk);

endmodule

// File: design/udc_counter_top.sv
// Four-bit up/down counter with asynchronous preset, cascade outputs and APB registers
//
// Functional notes
// - Four bit count, all bits clocked together
// - Count changes only at rising clock edge
// - Counts only while inhibit input is low
// - Direction low counts up, high down
// - Control changes act only at next edge
// - Load low forces count to data inputs
// - Preset is immediate, independent of clock
// - Upward wrap from fifteen to zero
// - Downward wrap from zero to fifteen
// - Terminal flag high at max up/min down
// - Ripple low at terminal during clock low
//
// The register addresses and the APB slave port were left to the implementer.
module udc_counter_top
    import udc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [APB_SW-1:0] pstrb,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Counter control pins
    input wire logic count_inhibit_n,
    input wire logic down_sel,
    input wire logic load_n,
    input wire logic [CNT_W-1:0] preset_data,
    // Counter outputs
    output logic [CNT_W-1:0] count_q,
    output logic term_count,
    output logic ripple_pulse_n,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic hold;
        logic [CNT_W-1:0] sw_preset;
        logic load_n_prev;
        logic [APB_DW-1:0] rdata;
        logic err;
    } udc_state_type;

    localparam udc_state_type ST_RESET = '{
        count: CNT_RESET,
        hold: 1'b0,
        sw_preset: CNT_RESET,
        load_n_prev: 1'b1,
        rdata: APB_ZERO,
        err: 1'b0
    };

    udc_state_type st_r;
    udc_state_type st_nxt;

    // Bus decode
    logic setup_ph;
    logic access_wr;
    logic hit_ctrl;
    logic hit_count;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic mapped;
    logic [APB_DW-1:0] wmask;
    logic [APB_DW-1:0] wmerged_ctrl;
    logic [APB_DW-1:0] ctrl_view;
    logic [APB_DW-1:0] count_view;
    logic [APB_DW-1:0] irq_status_view;
    logic [APB_DW-1:0] irq_mask_view;

    // Counter steering
    logic count_enable;
    logic sw_load;
    logic [CNT_W-1:0] sw_load_val;
    logic at_term_r;
    logic wrap_up_ev;
    logic wrap_down_ev;
    logic preset_ev;
    logic [IRQ_N-1:0] irq_events;

    // Interrupt bank access
    logic irq_clear_we;
    logic irq_mask_we;
    logic [IRQ_N-1:0] irq_status;
    logic [IRQ_N-1:0] irq_mask;

    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign hit_ctrl = (paddr == OFS_CTRL);
    assign hit_count = (paddr == OFS_COUNT);
    assign hit_irq_status = (paddr == OFS_IRQ_STATUS);
    assign hit_irq_mask = (paddr == OFS_IRQ_MASK);
    assign mapped = hit_ctrl | hit_count | hit_irq_status | hit_irq_mask;
    assign wmask = udc_strb_mask(pstrb);

    // Control word merged lane by lane with the written data
    assign wmerged_ctrl = (ctrl_view & ~wmask) | (pwdata & wmask);

    // Software hold gates counting like the inhibit pin does
    assign count_enable = ~count_inhibit_n & ~st_r.hold;

    // Software load is a write of one to the self-clearing load bit
    assign sw_load = access_wr & hit_ctrl & wmerged_ctrl[CTRL_LOAD_BIT];
    assign sw_load_val = wmerged_ctrl[CTRL_PRESET_LSB +: CNT_W];

    // Wrap events come from the stored count at a counting edge
    assign at_term_r = udc_at_terminal(st_r.count, down_sel);
    assign wrap_up_ev = load_n & ~sw_load & count_enable & ~down_sel & at_term_r;
    assign wrap_down_ev = load_n & ~sw_load & count_enable & down_sel & at_term_r;
    assign preset_ev = (~load_n & st_r.load_n_prev) | sw_load;

    always_comb begin
        irq_events = IRQ_RESET;
        irq_events[IRQ_WRAP_UP] = wrap_up_ev;
        irq_events[IRQ_WRAP_DOWN] = wrap_down_ev;
        irq_events[IRQ_PRESET] = preset_ev;
    end

    assign irq_clear_we = access_wr & hit_irq_status;
    assign irq_mask_we = access_wr & hit_irq_mask;

    // Read views, unused bits read as zero
    always_comb begin
        ctrl_view = APB_ZERO;
        ctrl_view[CTRL_HOLD_BIT] = st_r.hold;
        ctrl_view[CTRL_PRESET_LSB +: CNT_W] = st_r.sw_preset;
    end

    always_comb begin
        count_view = APB_ZERO;
        count_view[COUNT_VAL_LSB +: CNT_W] = count_q;
        count_view[COUNT_TC_BIT] = term_count;
        count_view[COUNT_DIR_BIT] = down_sel;
        count_view[COUNT_INH_BIT] = ~count_enable;
        count_view[COUNT_LOAD_BIT] = ~load_n;
    end

    always_comb begin
        irq_status_view = APB_ZERO;
        irq_status_view[IRQ_N-1:0] = irq_status;
        irq_mask_view = APB_ZERO;
        irq_mask_view[IRQ_N-1:0] = irq_mask;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.load_n_prev = load_n;

        // Count path; controls act here at the clock edge, but load_n also steers count_q directly
        if (!load_n) begin
            st_nxt.count = preset_data;
        end else if (sw_load) begin
            st_nxt.count = sw_load_val;
        end else if (count_enable) begin
            st_nxt.count = udc_step(st_r.count, down_sel);
        end

        // Control register write
        if (access_wr && hit_ctrl) begin
            st_nxt.hold = wmerged_ctrl[CTRL_HOLD_BIT];
            st_nxt.sw_preset = sw_load_val;
        end

        // Read data and error latched in setup so the access phase needs no wait
        if (setup_ph) begin
            st_nxt.err = ~mapped;
            unique case (1'b1)
                hit_ctrl: st_nxt.rdata = ctrl_view;
                hit_count: st_nxt.rdata = count_view;
                hit_irq_status: st_nxt.rdata = irq_status_view;
                hit_irq_mask: st_nxt.rdata = irq_mask_view;
                default: st_nxt.rdata = APB_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Preset bypasses the flip-flops so the pins follow without a clock edge
    assign count_q = load_n ? st_r.count : preset_data;

    udc_cascade u_cascade (
        .clk(clk),
        .count_val(count_q),
        .down_sel(down_sel),
        .count_enable(count_enable),
        .term_count(term_count),
        .ripple_pulse_n(ripple_pulse_n)
    );

    udc_irq_bank #(
        .N(IRQ_N)
    ) u_irq (
        .clk(clk),
        .resetn(resetn),
        .event_set(irq_events),
        .clear_we(irq_clear_we),
        .clear_bits(pwdata[IRQ_N-1:0] & wmask[IRQ_N-1:0]),
        .mask_we(irq_mask_we),
        .mask_bits((irq_mask & ~wmask[IRQ_N-1:0]) | (pwdata[IRQ_N-1:0] & wmask[IRQ_N-1:0])),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // Zero wait states; read data was captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = st_r.rdata;
    assign pslverr = psel & penable & st_r.err;

endmodule

// File: design/udc_irq_bank.sv
// Sticky interrupt status with write-one-to-clear, mask and level output
module udc_irq_bank
    import udc_pkg::*;
#(
    parameter int N = IRQ_N
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Event inputs
    input wire logic [N-1:0] event_set,
    // Software access
    input wire logic clear_we,
    input wire logic [N-1:0] clear_bits,
    input wire logic mask_we,
    input wire logic [N-1:0] mask_bits,
    // State and interrupt
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic irq;
    } udc_irq_state_type;

    udc_irq_state_type st_r;
    udc_irq_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Set wins so an event in the clearing cycle survives
        if (clear_we) begin
            st_nxt.status = st_r.status & ~clear_bits;
        end
        st_nxt.status = st_nxt.status | event_set;
        if (mask_we) begin
            st_nxt.mask = mask_bits;
        end
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= '{status: '0, mask: '0, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status = st_r.status;
    assign mask = st_r.mask;
    assign irq = st_r.irq;

endmodule

// File: design/udc_pkg.sv
// Shared constants, register map and helper functions for the up/down counter
package udc_pkg;

    // Counter geometry and reset value
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] CNT_MIN = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

    // APB geometry
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int APB_SW = APB_DW / 8;
    localparam logic [APB_DW-1:0] APB_ZERO = 32'h0;

    // Register byte offsets
    localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] OFS_COUNT = 12'h004;
    localparam logic [APB_AW-1:0] OFS_IRQ_STATUS = 12'h008;
    localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 12'h00c;

    // Control register fields
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_LOAD_BIT = 4;
    localparam int CTRL_PRESET_LSB = 8;

    // Count register fields
    localparam int COUNT_VAL_LSB = 0;
    localparam int COUNT_TC_BIT = 4;
    localparam int COUNT_DIR_BIT = 5;
    localparam int COUNT_INH_BIT = 6;
    localparam int COUNT_LOAD_BIT = 7;

    // Interrupt status and mask fields
    localparam int IRQ_N = 3;
    localparam int IRQ_WRAP_UP = 0;
    localparam int IRQ_WRAP_DOWN = 1;
    localparam int IRQ_PRESET = 2;
    localparam logic [IRQ_N-1:0] IRQ_RESET = 3'h0;

    // One count step in the selected direction, wrapping modulo sixteen
    function automatic logic [CNT_W-1:0] udc_step(input logic [CNT_W-1:0] cnt, input logic down);
        udc_step = down ? (cnt - CNT_ONE) : (cnt + CNT_ONE);
    endfunction

    // Maximum counting up or minimum counting down
    function automatic logic udc_at_terminal(input logic [CNT_W-1:0] cnt, input logic down);
        udc_at_terminal = down ? (cnt == CNT_MIN) : (cnt == CNT_MAX);
    endfunction

    // Byte strobes widened to a bit mask
    function automatic logic [APB_DW-1:0] udc_strb_mask(input logic [APB_SW-1:0] strb);
        logic [APB_DW-1:0] m;
        m = APB_ZERO;
        for (int i = 0; i < APB_SW; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        udc_strb_mask = m;
    endfunction

endpackage

// File: verification/testbench.sv
// Self-checking bench for the up/down counter
module testbench
    import udc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic [APB_DW-1:0] pwdata = 32'h0, prdata, r;
    logic [APB_SW-1:0] pstrb = 4'hf;
    logic pready, pslverr, term_count, ripple_pulse_n, irq;
    logic count_inhibit_n = 1'b1, down_sel = 1'b0, load_n = 1'b1;
    logic [CNT_W-1:0] preset_data = 4'h0, count_q, e, hi_q, la_q;
    int err_count = 0, cmp_count = 0, cyc = 0;
    always #10 clk = ~clk;
    udc_counter_top uut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_inhibit_n(count_inhibit_n), .down_sel(down_sel), .load_n(load_n), .preset_data(preset_data),
        .count_q(count_q), .term_count(term_count), .ripple_pulse_n(ripple_pulse_n), .irq(irq));
    udc_stage_model u_next (.clk(clk), .resetn(resetn), .down_sel(down_sel), .ripple_pulse_n(ripple_pulse_n),
        .hi_q(hi_q), .term_count(term_count), .count_inhibit_n(count_inhibit_n), .la_q(la_q));
    task automatic give_verdict();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
        output logic [APB_DW-1:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Inhibit is raised on the last counting edge, so that edge still counts
    task automatic run(input int n, input logic dn);
        @(posedge clk);
        down_sel <= dn;
        count_inhibit_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            if (k == n - 1) count_inhibit_n <= 1'b1;
            #1 e = dn ? e - 4'h1 : e + 4'h1;
            chk("count", count_q, e);
            chk("term", term_count, e == (dn ? 4'h0 : 4'hf));
            chk("ripple high phase", ripple_pulse_n, 1'b1);
            #10 chk("ripple low phase", ripple_pulse_n, !(e == (dn ? 4'h0 : 4'hf) && k != n - 1));
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, OFS_IRQ_STATUS, 32'h0, r);
        chk("status reset", r, 32'h0);
        @(posedge clk);
        preset_data <= 4'hd;
        load_n <= 1'b0;
        count_inhibit_n <= 1'b0;
        #1 chk("preset at once", count_q, 4'hd);
        repeat (2) @(posedge clk);
        #1 chk("preset held", count_q, 4'hd);
        @(posedge clk);
        load_n <= 1'b1;
        count_inhibit_n <= 1'b1;
        #1 chk("preset wins", count_q, 4'hd);
        e = 4'hd;
        run(2, 1'b0);
        run(3, 1'b0);
        chk("next stage up", hi_q, 4'h1);
        chk("look-ahead up", la_q, 4'h1);
        repeat (3) @(posedge clk);
        #1 chk("inhibited", count_q, 4'h2);
        run(5, 1'b1);
        chk("next stage down", hi_q, 4'h0);
        chk("look-ahead down", la_q, 4'h0);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0, r);
        chk("status", r, 32'h7);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h7, r);
        @(posedge clk);
        #1 chk("irq on", irq, 1'b1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h7, r);
        @(posedge clk);
        #1 chk("irq cleared", irq, 1'b0);
        apb(1'b0, 12'h100, 32'h0, r);
        chk("unmapped", r, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1, r);
        @(posedge clk);
        count_inhibit_n <= 1'b0;
        repeat (3) @(posedge clk);
        count_inhibit_n <= 1'b1;
        #1 chk("software hold", count_q, 4'hd);
        apb(1'b1, OFS_CTRL, 32'h510, r);
        apb(1'b1, OFS_COUNT, 32'h0, r);
        apb(1'b0, OFS_COUNT, 32'h0, r);
        chk("count reg", r, 32'h65);
        apb(1'b0, OFS_CTRL, 32'h0, r);
        chk("ctrl reg", r, 32'h500);
        give_verdict();
    end
endmodule

// File: verification/udc_counter_props.sv
// Checker for counter pins, cascade outputs and APB answers
module udc_counter_props
    import udc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [APB_SW-1:0] pstrb,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Counter pins
    input wire logic count_inhibit_n,
    input wire logic down_sel,
    input wire logic load_n,
    input wire logic [CNT_W-1:0] preset_data,
    input wire logic [CNT_W-1:0] count_q,
    input wire logic term_count,
    input wire logic ripple_pulse_n,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hold_r;
    logic ctrl_wr;
    logic en;
    // Mirror of the software hold bit, so ripple and stepping can be judged
    assign ctrl_wr = psel && pwrite && paddr == OFS_CTRL;
    assign en = load_n && !count_inhibit_n && !hold_r && !ctrl_wr;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hold_r <= 1'b0;
        end else if (ctrl_wr && penable && pstrb[0]) begin
            hold_r <= pwdata[CTRL_HOLD_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_UP: assert property ($past(resetn && en && !down_sel) && load_n
        |-> count_q == $past(count_q) + CNT_ONE) else $error("count did not step up");
    AST_DOWN: assert property ($past(resetn && en && down_sel) && load_n
        |-> count_q == $past(count_q) - CNT_ONE) else $error("count did not step down");
    AST_INHIBIT: assert property ($past(resetn && load_n && count_inhibit_n && !ctrl_wr) && load_n
        |-> $stable(count_q)) else $error("count moved while inhibited");
    AST_LOAD: assert property (!load_n |-> count_q == preset_data)
        else $error("preset not followed");
    AST_TC: assert property (term_count ==
        ((count_q == CNT_MAX && !down_sel) || (count_q == CNT_MIN && down_sel))) else $error("terminal flag wrong");
    AST_RIPPLE_LO: assert property (ripple_pulse_n == !(term_count && !count_inhibit_n && !hold_r))
        else $error("ripple wrong in low phase");
    AST_RIPPLE_HI: assert property (@(negedge clk) ripple_pulse_n)
        else $error("ripple low in high phase");
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    AST_SLVERR: assert property (psel && penable && paddr > OFS_IRQ_MASK |-> pslverr)
        else $error("unmapped access not flagged");
    cover property (count_q == CNT_MAX && !down_sel && !count_inhibit_n);
    cover property (!ripple_pulse_n);
    cover property (irq);
endmodule

bind udc_counter_top udc_counter_props u_props (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_inhibit_n(count_inhibit_n), .down_sel(down_sel), .load_n(load_n),
    .preset_data(preset_data), .count_q(count_q), .term_count(term_count), .ripple_pulse_n(ripple_pulse_n),
    .irq(irq));

// File: verification/udc_stage_model.sv
// Next cascaded stage, enabled by the ripple pulse (hi_q) or by look-ahead (la_q) on a shared clock
module udc_stage_model
    import udc_pkg::*;
(
    // Shared clock and control
    input wire logic clk,
    input wire logic resetn,
    input wire logic down_sel,
    // Carry or borrow in
    input wire logic ripple_pulse_n,
    // Look-ahead inputs
    input wire logic term_count,
    input wire logic count_inhibit_n,
    // Upper count, by ripple and by look-ahead
    output logic [CNT_W-1:0] hi_q,
    output logic [CNT_W-1:0] la_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen = 1'b0;
    // Ripple is only low in the low phase, so look mid-phase
    always @(negedge clk) begin
        #5 seen = !ripple_pulse_n;
    end
    // Look-ahead avoids waiting for the ripple's low phase
    always @(posedge clk) begin
        if (!resetn) begin
            la_q <= 4'h0;
        end else if (term_count && !count_inhibit_n) begin
            la_q <= down_sel ? la_q - 4'h1 : la_q + 4'h1;
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            hi_q <= 4'h0;
        end else if (seen) begin
            hi_q <= down_sel ? hi_q - 4'h1 : hi_q + 4'h1;
        end
    end
endmodule
